// ### rtl/etl_pkg.sv
package etl_pkg;

	// ====================================================
	// stream geometry
	localparam int unsigned TAPS = 8;
	localparam int unsigned PIX_W = 8;
	localparam int unsigned WORD_W = TAPS * PIX_W;
	localparam int unsigned LINE_PIX_MAX = 4096;
	localparam int unsigned LINE_PIX_SMALL = 2048;
	localparam int unsigned LEN_W = 13;
	localparam int unsigned DEPTH = LINE_PIX_MAX / TAPS;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned CNT_W = 10;
	localparam logic [LEN_W-1:0] TAP_ROUND = 13'h0007;
	localparam int unsigned TAP_SHIFT = 3;

	// ====================================================
	// serializer input positions, one transmitter
	localparam int unsigned TX_W = 28;
	localparam int unsigned SPARE_BIT = 23;
	localparam int unsigned LVAL_BIT = 24;
	localparam int unsigned FVAL_BIT = 25;
	localparam int unsigned DVAL_BIT = 26;
	localparam int unsigned POS_P0 [0:7] = '{0, 1, 2, 3, 4, 6, 27, 5};
	localparam int unsigned POS_P1 [0:7] = '{7, 8, 9, 12, 13, 14, 10, 11};
	localparam int unsigned POS_P2 [0:7] = '{15, 18, 19, 20, 21, 22, 16, 17};
	localparam logic [TX_W-1:0] TX_IDLE = 28'h0000000;

	typedef logic [WORD_W-1:0] etl_word_t;
	typedef logic [LEN_W-1:0] etl_len_t;
	typedef logic [ADDR_W-1:0] etl_addr_t;
	typedef logic [CNT_W-1:0] etl_cnt_t;
	typedef logic [TX_W-1:0] etl_tx_t;
	typedef logic [PIX_W-1:0] etl_pix_t;

	// ====================================================
	// port mapping, shared by both ends
	function automatic etl_tx_t etl_pack(input etl_pix_t p0, input etl_pix_t p1, input etl_pix_t p2,
		input logic lval, input logic dval);
		etl_tx_t t;
		t = TX_IDLE;
		for (int i = 0; i < 8; i++) begin
			t[POS_P0[i]] = p0[i];
			t[POS_P1[i]] = p1[i];
			t[POS_P2[i]] = p2[i];
		end
		t[LVAL_BIT] = lval;
		t[DVAL_BIT] = dval;
		return t;
	endfunction

	function automatic etl_pix_t etl_unpack(input etl_tx_t t, input int unsigned port);
		etl_pix_t p;
		p = '0;
		for (int i = 0; i < 8; i++) begin
			case (port)
				0: p[i] = t[POS_P0[i]];
				1: p[i] = t[POS_P1[i]];
				default: p[i] = t[POS_P2[i]];
			endcase
		end
		return p;
	endfunction

endpackage

// ### rtl/etl_link_if.sv
`timescale 1ns/10ps
interface etl_link_if;
	logic pix_clk;
	logic [27:0] tx_x;
	logic [27:0] tx_y;
	logic [27:0] tx_z;

	modport cam (input pix_clk, output tx_x, output tx_y, output tx_z);
	modport grab (input pix_clk, input tx_x, input tx_y, input tx_z);
endinterface

// ### rtl/etl_pulse_sync.sv
`timescale 1ns/10ps
module etl_pulse_sync (
	input wire logic src_clk_i,
	input wire logic src_rst_i,
	input wire logic src_pulse_i,
	input wire logic dst_clk_i,
	input wire logic dst_rst_i,
	output logic dst_pulse_o
);
	// ====================================================
	// toggle crossing: one event per source pulse
	logic tog_r, tog_nxt;
	logic meta_r, sync_r, prev_r;

	always_comb begin
		tog_nxt = tog_r ^ src_pulse_i;
	end

	always_ff @(posedge src_clk_i) begin
		if (src_rst_i) begin
			tog_r <= 1'b0;
		end else begin
			tog_r <= tog_nxt;
		end
	end

	always_ff @(posedge dst_clk_i) begin
		if (dst_rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= tog_r;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign dst_pulse_o = sync_r ^ prev_r;
endmodule

// ### rtl/etl_cam_tx.sv
`timescale 1ns/10ps
// Function
// - eight 8-bit pixels plus two qualifiers per cycle
// - spread taps over transmitters X, Y, Z
// - launch everything on pixel clock rising edge
// - grabber keeps pixel only with both qualifiers
// - qualifiers low whenever nothing valid is sent
// - send a line only after acquisition ends
// - first cycle: pixels 1..8 on taps 0..7
// - each next cycle advances eight pixels
// - qualifiers drop together after last word
// - X: taps 0..2, qualifiers on 24, 26
// - nonlinear serializer input order per port
// - Y: taps 3..5, same placement as X
// - Z: taps 6..7, qualifiers as X, port 2 spare and zero
// - line length 4096/2048, taken from line_len_i at line end
module etl_cam_tx (
	input wire logic clk_i,
	input wire logic rst_i,
	etl_link_if.cam link,
	input wire logic pix_wr_i,
	input wire etl_pkg::etl_word_t pix_word_i,
	input wire logic line_end_i,
	input wire etl_pkg::etl_len_t line_len_i,
	output logic busy_o,
	output logic line_sent_o,
	output logic wr_drop_o
);
	import etl_pkg::*;

	typedef enum logic [1:0] {
		ETL_IDLE = 2'b00,
		ETL_SEND = 2'b01
	} etl_state_t;

	// ====================================================
	// line memory: written on clk_i, read on the pixel clock
	etl_word_t mem [0:DEPTH-1];

	// ====================================================
	// acquisition side, clk_i
	logic busy_r, busy_nxt;
	logic sent_r, sent_nxt;
	logic drop_r, drop_nxt;
	etl_addr_t wr_ptr_r, wr_ptr_nxt;
	etl_len_t len_r, len_nxt;
	logic start_r, start_nxt;
	logic wr_en;
	logic done_clk;

	always_comb begin
		busy_nxt = busy_r;
		sent_nxt = 1'b0;
		drop_nxt = 1'b0;
		wr_ptr_nxt = wr_ptr_r;
		len_nxt = len_r;
		start_nxt = 1'b0;
		wr_en = 1'b0;
		if (busy_r) begin
			// memory is being read out; refuse new data
			drop_nxt = pix_wr_i;
			if (done_clk) begin
				busy_nxt = 1'b0;
				sent_nxt = 1'b1;
			end
		end else begin
			if (pix_wr_i) begin
				wr_en = 1'b1;
				wr_ptr_nxt = wr_ptr_r + 9'h001;
			end
			if (line_end_i) begin
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				len_nxt = line_len_i;
				wr_ptr_nxt = '0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			sent_r <= 1'b0;
			drop_r <= 1'b0;
			wr_ptr_r <= '0;
			len_r <= '0;
			start_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			sent_r <= sent_nxt;
			drop_r <= drop_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			len_r <= len_nxt;
			start_r <= start_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_en) begin
			mem[wr_ptr_r] <= pix_word_i;
		end
	end

	assign busy_o = busy_r;
	assign line_sent_o = sent_r;
	assign wr_drop_o = drop_r;

	// ====================================================
	// pixel clock reset
	logic prst_meta_r, prst_r;

	always_ff @(posedge link.pix_clk) begin
		prst_meta_r <= rst_i;
		prst_r <= prst_meta_r;
	end

	// ====================================================
	// crossings
	logic start_pix;
	logic done_r, done_nxt;

	etl_pulse_sync u_start_sync (
		.src_clk_i(clk_i),
		.src_rst_i(rst_i),
		.src_pulse_i(start_r),
		.dst_clk_i(link.pix_clk),
		.dst_rst_i(prst_r),
		.dst_pulse_o(start_pix)
	);

	etl_pulse_sync u_done_sync (
		.src_clk_i(link.pix_clk),
		.src_rst_i(prst_r),
		.src_pulse_i(done_r),
		.dst_clk_i(clk_i),
		.dst_rst_i(rst_i),
		.dst_pulse_o(done_clk)
	);

	// ====================================================
	// read-out sequencer, pixel clock
	etl_state_t state_r, state_nxt;
	etl_addr_t rd_ptr_r, rd_ptr_nxt;
	etl_cnt_t words_r, words_nxt;
	etl_len_t len_round;
	logic rd_en;

	always_comb begin
		state_nxt = state_r;
		rd_ptr_nxt = rd_ptr_r;
		words_nxt = words_r;
		done_nxt = 1'b0;
		rd_en = 1'b0;
		// len_r stays still while busy, so it is safe to read here
		len_round = len_r + TAP_ROUND;
		case (state_r)
			ETL_IDLE: begin
				if (start_pix) begin
					words_nxt = CNT_W'(len_round >> TAP_SHIFT);
					rd_ptr_nxt = '0;
					if (words_nxt != '0) begin
						state_nxt = ETL_SEND;
					end else begin
						done_nxt = 1'b1;
					end
				end
			end
			ETL_SEND: begin
				rd_en = 1'b1;
				rd_ptr_nxt = rd_ptr_r + 9'h001;
				if ({1'b0, rd_ptr_r} == words_r - 10'h001) begin
					state_nxt = ETL_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: begin
				state_nxt = ETL_IDLE;
			end
		endcase
	end

	always_ff @(posedge link.pix_clk) begin
		if (prst_r) begin
			state_r <= ETL_IDLE;
			rd_ptr_r <= '0;
			words_r <= '0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			words_r <= words_nxt;
			done_r <= done_nxt;
		end
	end

	// ====================================================
	// output stage: one read cycle, then one launch register
	etl_word_t rd_data_r, rd_data_nxt;
	logic vld_r, vld_nxt;
	etl_tx_t tx_x_r, tx_x_nxt;
	etl_tx_t tx_y_r, tx_y_nxt;
	etl_tx_t tx_z_r, tx_z_nxt;
	etl_pix_t tap [0:7];

	always_comb begin
		rd_data_nxt = rd_en ? mem[rd_ptr_r] : '0;
		vld_nxt = rd_en;
		for (int k = 0; k < TAPS; k++) begin
			// tap k holds pixel 8c+k+1: lowest byte is the earliest pixel
			tap[k] = rd_data_r[k*PIX_W +: PIX_W];
		end
		// both qualifiers come from one flag, so they never differ
		tx_x_nxt = etl_pack(tap[0], tap[1], tap[2], vld_r, vld_r);
		tx_y_nxt = etl_pack(tap[3], tap[4], tap[5], vld_r, vld_r);
		tx_z_nxt = etl_pack(tap[6], tap[7], 8'h00, vld_r, vld_r);
	end

	always_ff @(posedge link.pix_clk) begin
		if (prst_r) begin
			rd_data_r <= '0;
			vld_r <= 1'b0;
			tx_x_r <= TX_IDLE;
			tx_y_r <= TX_IDLE;
			tx_z_r <= TX_IDLE;
		end else begin
			rd_data_r <= rd_data_nxt;
			vld_r <= vld_nxt;
			tx_x_r <= tx_x_nxt;
			tx_y_r <= tx_y_nxt;
			tx_z_r <= tx_z_nxt;
		end
	end

	assign link.tx_x = tx_x_r;
	assign link.tx_y = tx_y_r;
	assign link.tx_z = tx_z_r;
endmodule

// ### rtl/etl_grab_rx.sv
`timescale 1ns/10ps
module etl_grab_rx (
	input wire logic clk_i,
	input wire logic rst_i,
	etl_link_if.grab link,
	input wire etl_pkg::etl_addr_t rd_addr_i,
	output etl_pkg::etl_word_t rd_data_o,
	output logic line_ready_o,
	output etl_pkg::etl_cnt_t line_words_o
);
	import etl_pkg::*;

	// ====================================================
	// line capture, pixel clock
	etl_word_t mem [0:DEPTH-1];
	logic prst_meta_r, prst_r;

	always_ff @(posedge link.pix_clk) begin
		prst_meta_r <= rst_i;
		prst_r <= prst_meta_r;
	end

	logic in_line_r, in_line_nxt;
	etl_cnt_t wr_cnt_r, wr_cnt_nxt;
	etl_cnt_t words_r, words_nxt;
	logic end_r, end_nxt;
	logic take;
	etl_word_t word_in;

	always_comb begin
		in_line_nxt = in_line_r;
		wr_cnt_nxt = wr_cnt_r;
		words_nxt = words_r;
		end_nxt = 1'b0;
		// pixels count only with both qualifiers high
		take = link.tx_x[LVAL_BIT] & link.tx_x[DVAL_BIT];
		word_in = {etl_unpack(link.tx_z, 1), etl_unpack(link.tx_z, 0),
			etl_unpack(link.tx_y, 2), etl_unpack(link.tx_y, 1), etl_unpack(link.tx_y, 0),
			etl_unpack(link.tx_x, 2), etl_unpack(link.tx_x, 1), etl_unpack(link.tx_x, 0)};
		if (take) begin
			in_line_nxt = 1'b1;
			wr_cnt_nxt = wr_cnt_r + 10'h001;
		end else if (in_line_r) begin
			// next line overwrites the memory; software must read in time
			in_line_nxt = 1'b0;
			words_nxt = wr_cnt_r;
			wr_cnt_nxt = '0;
			end_nxt = 1'b1;
		end
	end

	always_ff @(posedge link.pix_clk) begin
		if (prst_r) begin
			in_line_r <= 1'b0;
			wr_cnt_r <= '0;
			words_r <= '0;
			end_r <= 1'b0;
		end else begin
			in_line_r <= in_line_nxt;
			wr_cnt_r <= wr_cnt_nxt;
			words_r <= words_nxt;
			end_r <= end_nxt;
		end
	end

	always_ff @(posedge link.pix_clk) begin
		if (take && wr_cnt_r < CNT_W'(DEPTH)) begin
			mem[wr_cnt_r[ADDR_W-1:0]] <= word_in;
		end
	end

	// ====================================================
	// user side, clk_i
	logic end_clk;

	etl_pulse_sync u_end_sync (
		.src_clk_i(link.pix_clk),
		.src_rst_i(prst_r),
		.src_pulse_i(end_r),
		.dst_clk_i(clk_i),
		.dst_rst_i(rst_i),
		.dst_pulse_o(end_clk)
	);

	logic rdy_r, rdy_nxt;
	etl_cnt_t cnt_r, cnt_nxt;
	etl_word_t data_r, data_nxt;

	always_comb begin
		rdy_nxt = end_clk;
		// words_r is held still long after the end event
		cnt_nxt = end_clk ? words_r : cnt_r;
		data_nxt = mem[rd_addr_i];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdy_r <= 1'b0;
			cnt_r <= '0;
			data_r <= '0;
		end else begin
			rdy_r <= rdy_nxt;
			cnt_r <= cnt_nxt;
			data_r <= data_nxt;
		end
	end

	assign line_ready_o = rdy_r;
	assign line_words_o = cnt_r;
	assign rd_data_o = data_r;
endmodule

// ### verification/etl_link_props.sv
`timescale 1ns/10ps
// ====================================================
// link wire checks, pixel clock domain
module etl_link_props (
	input wire logic pix_clk_i,
	input wire logic rst_i,
	input wire logic [27:0] tx_x_i,
	input wire logic [27:0] tx_y_i,
	input wire logic [27:0] tx_z_i
);
	logic [9:0] run_r;
	logic [9:0] run_nxt;

	// ====================================================
	// run length of the qualifiers, capped only by the assertion
	always_comb begin
		run_nxt = (rst_i || !tx_x_i[24]) ? 10'h000 : run_r + 10'h001;
	end
	always_ff @(posedge pix_clk_i) begin
		run_r <= run_nxt;
	end

	default clocking cb @(posedge pix_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence line_open;
		$rose(tx_x_i[24]);
	endsequence
	sequence line_close;
		$fell(tx_x_i[24]);
	endsequence

	// ====================================================
	// assertions
	a_qual_pair: assert property (tx_x_i[24] == tx_x_i[26]) else $error("x qualifiers differ");
	a_qual_y: assert property (tx_y_i[24] == tx_x_i[24] && tx_y_i[26] == tx_x_i[26])
		else $error("y qualifiers");
	a_qual_z: assert property (tx_z_i[24] == tx_x_i[24] && tx_z_i[26] == tx_x_i[26])
		else $error("z qualifiers");
	a_unused_bits: assert property (!(tx_x_i[25] | tx_x_i[23] | tx_y_i[25] | tx_y_i[23] | tx_z_i[25] | tx_z_i[23]))
		else $error("unused input driven");
	a_spare_z: assert property (tx_z_i[22:15] == 8'h00) else $error("z spare inputs driven");
	a_start_both: assert property (line_open |-> $rose(tx_x_i[26]) && $rose(tx_y_i[24]))
		else $error("ragged start");
	a_end_both: assert property (line_close |-> $fell(tx_x_i[26]) && !tx_z_i[24]) else $error("ragged end");
	a_idle_gap: assert property (line_close |-> !tx_x_i[24] [*3]) else $error("no idle after line");
	a_line_len: assert property (run_r <= 10'h200) else $error("line longer than 512 words");
endmodule

// ### verification/test_eight_tap_8bit_line_output.sv
`timescale 1ns/10ps
module test_eight_tap_8bit_line_output;
	import etl_pkg::*;
	logic clk_i;
	logic rst_i;
	logic pix_wr_i;
	etl_word_t pix_word_i;
	logic line_end_i;
	etl_len_t line_len_i;
	logic busy_o;
	logic line_sent_o;
	logic wr_drop_o;
	etl_addr_t rd_addr_i;
	etl_word_t rd_data_o;
	logic line_ready_o;
	etl_cnt_t line_words_o;
	int err_count = 0;
	int checks_done = 0;
	int mon_idx;
	int ready_cnt;
	int pix_base;
	// serializer positions kept apart from the design's tables on purpose
	int pos [0:23] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8, 9, 12, 13, 14, 10, 11, 15, 18, 19, 20, 21, 22, 16, 17};

	etl_link_if etl_link_if_inst ();
	etl_cam_tx etl_cam_tx_inst (.clk_i(clk_i), .rst_i(rst_i), .link(etl_link_if_inst), .pix_wr_i(pix_wr_i),
		.pix_word_i(pix_word_i), .line_end_i(line_end_i), .line_len_i(line_len_i), .busy_o(busy_o),
		.line_sent_o(line_sent_o), .wr_drop_o(wr_drop_o));
	etl_grab_rx etl_grab_rx_inst (.clk_i(clk_i), .rst_i(rst_i), .link(etl_link_if_inst), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o), .line_ready_o(line_ready_o), .line_words_o(line_words_o));
	etl_link_props etl_link_props_inst (.pix_clk_i(etl_link_if_inst.pix_clk), .rst_i(rst_i),
		.tx_x_i(etl_link_if_inst.tx_x), .tx_y_i(etl_link_if_inst.tx_y), .tx_z_i(etl_link_if_inst.tx_z));

	// ====================================================
	// helpers
	function automatic etl_word_t exp_word(input int n, input int s);
		etl_word_t w;
		for (int k = 0; k < 8; k++) begin
			w[8*k +: 8] = 8'(8 * n + k + 1 + s);
		end
		return w;
	endfunction

	function automatic etl_word_t wire_word();
		etl_word_t w;
		logic [27:0] t [0:2];
		t = '{etl_link_if_inst.tx_x, etl_link_if_inst.tx_y, etl_link_if_inst.tx_z};
		for (int k = 0; k < 64; k++) begin
			w[k] = t[k / 24][pos[k % 24]];
		end
		return w;
	endfunction

	task chk_val(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// which 0: line sent, 1: grabber line ready
	task wait_flag(input int which);
		int i;
		for (i = 0; i < 20000; i++) begin
			@(negedge clk_i);
			if (which == 0 ? line_sent_o === 1'b1 : ready_cnt > 0) begin
				break;
			end
		end
		if (i == 20000) begin
			err_count++;
			$display("unexpected at %0t: wait ran out", $time);
			print_verdict();
		end
	endtask

	task run_line(input int n, input int s);
		int w;
		w = (n + 7) / 8;
		pix_base = s;
		mon_idx = 0;
		ready_cnt = 0;
		for (int i = 0; i < w; i++) begin
			@(posedge clk_i);
			pix_wr_i <= 1'b1;
			pix_word_i <= exp_word(i, s);
		end
		@(posedge clk_i);
		pix_wr_i <= 1'b0;
		line_end_i <= 1'b1;
		line_len_i <= 13'(n);
		@(posedge clk_i);
		line_end_i <= 1'b0;
		pix_wr_i <= (n > 0);
		pix_word_i <= '0;
		@(posedge clk_i);
		pix_wr_i <= 1'b0;
		#1;
		if (n > 0) begin
			chk_val(busy_o, 1'b1);
			chk_val(wr_drop_o, 1'b1);
		end
		wait_flag(0);
		// busy drops in the same cycle as the sent pulse
		chk_val(busy_o, 1'b0);
		if (n == 0) begin
			repeat (40) @(posedge clk_i);
		end else begin
			wait_flag(1);
			chk_val(line_words_o, w);
		end
		chk_val(mon_idx, w);
		chk_val(ready_cnt, n > 0);
		for (int i = 0; i < w; i++) begin
			@(posedge clk_i);
			rd_addr_i <= 9'(i);
			@(posedge clk_i);
			#1;
			chk_val(rd_data_o, exp_word(i, s));
		end
	endtask

	// ====================================================
	// monitors: raw wire decode and grabber pulse count
	always @(negedge etl_link_if_inst.pix_clk) begin
		if (etl_link_if_inst.tx_x[24] === 1'b1 && etl_link_if_inst.tx_x[26] === 1'b1) begin
			chk_val(wire_word(), exp_word(mon_idx, pix_base));
			mon_idx++;
		end
	end
	always @(posedge clk_i) begin
		if (line_ready_o === 1'b1) begin
			ready_cnt <= ready_cnt + 1;
		end
	end

	// ====================================================
	// clocks and sequence
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		etl_link_if_inst.pix_clk = 1'b0;
		#7;
		forever #16 etl_link_if_inst.pix_clk = ~etl_link_if_inst.pix_clk;
	end
	initial begin
		rst_i = 1'b1;
		pix_wr_i = 1'b0;
		pix_word_i = '0;
		line_end_i = 1'b0;
		line_len_i = '0;
		rd_addr_i = '0;
		pix_base = 0;
		mon_idx = 0;
		ready_cnt = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		run_line(17, 48);
		run_line(8, 100);
		run_line(0, 0);
		run_line(4096, 7);
		run_line(2048, 3);
		print_verdict();
	end
endmodule
